// ===== src/ebt_consts.svh
// Function
// RL1 - Counter byte readable, resets to zero
// RL2 - Divider field picks tick divide 1 to 128
// RL3 - Divider change acts on next edge immediately
// RL4 - Run bit suspends or enables counting
// RL5 - Overflow event, masked by overflow mask bit
// RL6 - Writing one clears counter; reads zero
// RL7 - Clear bit reads zero after deep sleep
// RL8 - Mode 00 free runs zero to all-ones
// RL9 - Mode 01 counts down from compare value
// RL10 - Mode 10 counts zero to compare, restarts
// RL11 - Mode 11 counts up then down again
// RL12 - Bit 2 enables channel 0 compare
// RL13 - Bits 5:3 select channel output action
// RL14 - Actions 000 set, 001 clear, 010 toggle
// RL15 - Action 011 set up-match, clear at zero; in mode 11 code ignores zero, clears on down-count match
// RL16 - Action 100 clear up-match, set at zero; in mode 11 code ignores zero, sets on down-count match
// RL17 - Action 101 set match, clear at all-ones
// RL18 - Action 110 clear match, set at zero
// RL19 - Bit 6 masks channel 0 interrupt
// RL20 - Software writes zeros to reserved bits
// RL21 - Compare value register, read/write, reset zero
// RL22 - Overflow flag set by hardware, one ignored
// RL23 - Channel flag set by hardware, one ignored
`ifndef EBT_CONSTS_SVH
`define EBT_CONSTS_SVH

// Register indices; byte address is four times the index
`define EBT_IDX_COUNTER_VALUE   8'hea
`define EBT_IDX_TIMER_CONTROL   8'heb
`define EBT_IDX_CH0_CMP_CONTROL 8'hec
`define EBT_IDX_CH0_CMP_VALUE   8'hed
`define EBT_IDX_PENDING_FLAGS   8'hd8

// timer_control fields
`define EBT_CTL_DIV_HI   7
`define EBT_CTL_DIV_LO   5
`define EBT_CTL_RUN      4
`define EBT_CTL_OVERFLOW_IRQ_MASK    3
`define EBT_CTL_CLEAR    2
`define EBT_CTL_MODE_HI  1
`define EBT_CTL_MODE_LO  0

// channel0_compare_control fields
`define EBT_CCTL_IM      6
`define EBT_CCTL_ACT_HI  5
`define EBT_CCTL_ACT_LO  3
`define EBT_CCTL_EN      2
`define EBT_CCTL_RSV_HI  1
`define EBT_CCTL_RSV_LO  0

// Pending flag fields
`define EBT_FLG_CH0      4
`define EBT_FLG_OVF      3

// Reset values
`define EBT_RST_COUNT    8'h00
`define EBT_RST_DIV      3'h0
`define EBT_RST_MODE     2'h0
`define EBT_RST_ACT      3'h0
`define EBT_RST_CC0      8'h00
`define EBT_CNT_MAX      8'hff
`define EBT_CNT_ZERO     8'h00

`endif

// ===== src/ebt_pkg.sv
package ebt_pkg;

	typedef enum logic [1:0] {
		EBT_FREE   = 2'b00,
		EBT_DOWN   = 2'b01,
		EBT_MODULO = 2'b10,
		EBT_UPDOWN = 2'b11
	} ebt_mode_t;

	typedef enum logic [2:0] {
		EBT_ACT_SET      = 3'b000,
		EBT_ACT_CLR      = 3'b001,
		EBT_ACT_TGL      = 3'b010,
		EBT_ACT_SET_UP   = 3'b011,
		EBT_ACT_CLR_UP   = 3'b100,
		EBT_ACT_SET_MAX  = 3'b101,
		EBT_ACT_CLR_ZERO = 3'b110,
		EBT_ACT_NONE     = 3'b111
	} ebt_act_t;

	typedef struct packed {
		logic [7:0]  cnt;
		logic        down;
		logic [6:0]  presc;
		logic [2:0]  div;
		logic        run;
		logic        overflow_irq_mask;
		ebt_mode_t   mode;
		logic        im;
		ebt_act_t    act;
		logic        cen;
		logic [1:0]  rsv;
		logic [7:0]  cc0;
		logic        ovf_flag;
		logic        ch0_flag;
		logic        ch_out;
		logic        ovf_irq;
		logic        ch0_irq;
		logic        ack;
		logic [31:0] rdata;
	} ebt_state_t;

endpackage

// ===== src/ebt_timer.sv
`timescale 1ns/1ns
`include "ebt_consts.svh"

module ebt_timer
	import ebt_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        tick_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [9:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	output logic             ch0_out,
	output logic             ovf_irq_out,
	output logic             ch0_irq_out
);

	////////////////////////////////////////////////////////////////////////////
	// State

	localparam ebt_state_t RESET_STATE = '{
		cnt:      `EBT_RST_COUNT,
		down:     1'b0,
		presc:    7'h00,
		div:      `EBT_RST_DIV,
		run:      1'b0,
		overflow_irq_mask:    1'b1,
		mode:     EBT_FREE,
		im:       1'b1,
		act:      EBT_ACT_SET,
		cen:      1'b0,
		rsv:      2'h0,
		cc0:      `EBT_RST_CC0,
		ovf_flag: 1'b0,
		ch0_flag: 1'b0,
		ch_out:   1'b0,
		ovf_irq:  1'b0,
		ch0_irq:  1'b0,
		ack:      1'b0,
		rdata:    32'h0000_0000
	};

	ebt_state_t s;
	ebt_state_t next_s;

	logic       req;
	logic       wr;
	logic [7:0] idx;
	logic [6:0] div_mask;
	logic       step;
	logic [7:0] next_cnt;
	logic       next_down;
	logic       ovf_evt;
	logic       match;
	logic       hit_zero;
	logic       hit_max;
	logic       moving_down;
	logic       ctl_wr;
	logic       cctl_wr;
	logic       cc0_wr;
	logic       flg_wr;
	logic [7:0] wbyte;

	assign req   = wb_cyc_in & wb_stb_in & ~s.ack;
	assign wr    = req & wb_we_in & wb_sel_in[0];
	assign idx   = wb_adr_in[9:2];
	assign wbyte = wb_dat_in[7:0];

	assign ctl_wr  = wr && (idx == `EBT_IDX_TIMER_CONTROL);
	assign cctl_wr = wr && (idx == `EBT_IDX_CH0_CMP_CONTROL);
	assign cc0_wr  = wr && (idx == `EBT_IDX_CH0_CMP_VALUE);
	assign flg_wr  = wr && (idx == `EBT_IDX_PENDING_FLAGS);

	////////////////////////////////////////////////////////////////////////////
	// Prescaler

	// Mask taken from the live divider field, so a new value applies at once
	always_comb begin
		case (s.div)
			3'h0:    div_mask = 7'h00; // RL2
			3'h1:    div_mask = 7'h01;
			3'h2:    div_mask = 7'h03;
			3'h3:    div_mask = 7'h07;
			3'h4:    div_mask = 7'h0f;
			3'h5:    div_mask = 7'h1f;
			3'h6:    div_mask = 7'h3f;
			default: div_mask = 7'h7f;
		endcase
	end

	// No restart of the divider on a change: phase keeps running
	assign step = tick_in && ((s.presc & div_mask) == div_mask) && s.run; // RL3 RL4

	////////////////////////////////////////////////////////////////////////////
	// Counter step

	always_comb begin
		next_cnt  = s.cnt;
		next_down = s.down;
		ovf_evt   = 1'b0;
		case (s.mode)
			EBT_FREE: begin
				next_cnt = s.cnt + 8'h01; // RL8
				next_down = 1'b0;
				ovf_evt = (s.cnt == `EBT_CNT_MAX);
			end
			EBT_DOWN: begin
				// Stops at zero until reloaded by entering the mode again
				next_down = 1'b1;
				if (s.cnt != `EBT_CNT_ZERO) begin
					next_cnt = s.cnt - 8'h01; // RL9
					ovf_evt = (s.cnt == 8'h01);
				end
			end
			EBT_MODULO: begin
				next_down = 1'b0;
				if (s.cnt == s.cc0) begin
					next_cnt = `EBT_CNT_ZERO; // RL10
					ovf_evt = 1'b1;
				end else begin
					next_cnt = s.cnt + 8'h01;
				end
			end
			default: begin
				if (!s.down) begin
					if (s.cnt == s.cc0) begin
						next_down = (s.cc0 != `EBT_CNT_ZERO); // RL11
						next_cnt = (s.cc0 == `EBT_CNT_ZERO) ? s.cnt : s.cnt - 8'h01;
						ovf_evt = (s.cc0 == `EBT_CNT_ZERO);
					end else begin
						next_cnt = s.cnt + 8'h01;
					end
				end else begin
					if (s.cnt == `EBT_CNT_ZERO) begin
						next_down = 1'b0; // RL11
						next_cnt = (s.cc0 == `EBT_CNT_ZERO) ? s.cnt : 8'h01;
					end else begin
						next_cnt = s.cnt - 8'h01;
						ovf_evt = (s.cnt == 8'h01);
					end
				end
			end
		endcase
	end

	// Events seen on the value the counter moves to
	assign match       = step && s.cen && (next_cnt == s.cc0); // RL12 RL21
	assign hit_zero    = step && s.cen && (next_cnt == `EBT_CNT_ZERO);
	assign hit_max     = step && s.cen && (next_cnt == `EBT_CNT_MAX);
	assign moving_down = next_down && (s.mode == EBT_UPDOWN);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;

		if (tick_in) begin
			next_s.presc = s.presc + 7'h01;
		end

		if (step) begin
			next_s.cnt  = next_cnt;
			next_s.down = next_down;
		end

		// Channel output; secondary event first so the match decides a tie
		if (s.cen) begin
			case (s.act) // RL13
				EBT_ACT_SET_UP: begin
					if (s.mode != EBT_UPDOWN && hit_zero) begin
						next_s.ch_out = 1'b0; // RL15
					end
					if (match) begin
						next_s.ch_out = !moving_down; // RL15
					end
				end
				EBT_ACT_CLR_UP: begin
					if (s.mode != EBT_UPDOWN && hit_zero) begin
						next_s.ch_out = 1'b1; // RL16
					end
					if (match) begin
						next_s.ch_out = moving_down; // RL16
					end
				end
				EBT_ACT_SET_MAX: begin
					if (hit_max) begin
						next_s.ch_out = 1'b0; // RL17
					end
					if (match) begin
						next_s.ch_out = 1'b1; // RL17
					end
				end
				EBT_ACT_CLR_ZERO: begin
					if (hit_zero) begin
						next_s.ch_out = 1'b1; // RL18
					end
					if (match) begin
						next_s.ch_out = 1'b0; // RL18
					end
				end
				EBT_ACT_SET: begin
					if (match) begin
						next_s.ch_out = 1'b1; // RL14
					end
				end
				EBT_ACT_CLR: begin
					if (match) begin
						next_s.ch_out = 1'b0; // RL14
					end
				end
				EBT_ACT_TGL: begin
					if (match) begin
						next_s.ch_out = !s.ch_out; // RL14
					end
				end
				default: begin
					next_s.ch_out = s.ch_out;
				end
			endcase
		end

		// Register writes
		if (ctl_wr) begin
			next_s.div   = wbyte[`EBT_CTL_DIV_HI:`EBT_CTL_DIV_LO]; // RL2 RL3
			next_s.run   = wbyte[`EBT_CTL_RUN]; // RL4
			next_s.overflow_irq_mask = wbyte[`EBT_CTL_OVERFLOW_IRQ_MASK]; // RL5
			next_s.mode  = ebt_mode_t'(wbyte[`EBT_CTL_MODE_HI:`EBT_CTL_MODE_LO]);
			// Entering down mode loads the start value
			if (ebt_mode_t'(wbyte[`EBT_CTL_MODE_HI:`EBT_CTL_MODE_LO]) == EBT_DOWN
				&& s.mode != EBT_DOWN) begin
				next_s.cnt  = s.cc0; // RL9
				next_s.down = 1'b1;
			end
			if (wbyte[`EBT_CTL_CLEAR]) begin
				next_s.cnt  = `EBT_CNT_ZERO; // RL6
				next_s.down = 1'b0;
			end
		end
		if (cctl_wr) begin
			next_s.im  = wbyte[`EBT_CCTL_IM]; // RL19
			next_s.act = ebt_act_t'(wbyte[`EBT_CCTL_ACT_HI:`EBT_CCTL_ACT_LO]); // RL13
			next_s.cen = wbyte[`EBT_CCTL_EN]; // RL12
			// Stored as written; software keeps them zero
			next_s.rsv = wbyte[`EBT_CCTL_RSV_HI:`EBT_CCTL_RSV_LO]; // RL20
		end
		if (cc0_wr) begin
			next_s.cc0 = wbyte; // RL21
		end

		// Software may only clear flags; a same-cycle event wins
		if (flg_wr) begin
			next_s.ovf_flag = s.ovf_flag & wbyte[`EBT_FLG_OVF]; // RL22
			next_s.ch0_flag = s.ch0_flag & wbyte[`EBT_FLG_CH0]; // RL23
		end
		if (step && ovf_evt) begin
			next_s.ovf_flag = 1'b1; // RL5 RL22
		end
		if (match) begin
			next_s.ch0_flag = 1'b1; // RL23
		end

		next_s.ovf_irq = next_s.ovf_flag & next_s.overflow_irq_mask; // RL5
		next_s.ch0_irq = next_s.ch0_flag & next_s.im; // RL19

		////////////////////////////////////////////////////////////////////////
		// Bus answer, one cycle after the request

		next_s.ack = req;
		if (req) begin
			next_s.rdata = 32'h0000_0000;
			if (!wb_we_in) begin
				case (idx)
					`EBT_IDX_COUNTER_VALUE: begin
						next_s.rdata[7:0] = s.cnt; // RL1
					end
					`EBT_IDX_TIMER_CONTROL: begin
						// Clear bit always reads zero, also after sleep
						next_s.rdata[7:0] = {s.div, s.run, s.overflow_irq_mask, 1'b0, s.mode}; // RL6 RL7
					end
					`EBT_IDX_CH0_CMP_CONTROL: begin
						next_s.rdata[7:0] = {1'b0, s.im, s.act, s.cen, s.rsv};
					end
					`EBT_IDX_CH0_CMP_VALUE: begin
						next_s.rdata[7:0] = s.cc0; // RL21
					end
					`EBT_IDX_PENDING_FLAGS: begin
						next_s.rdata[`EBT_FLG_OVF] = s.ovf_flag; // RL22
						next_s.rdata[`EBT_FLG_CH0] = s.ch0_flag; // RL23
					end
					default: begin
						next_s.rdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s <= RESET_STATE; // RL1
		end else begin
			s <= next_s;
		end
	end

	assign wb_dat_out  = s.rdata;
	assign wb_ack_out  = s.ack;
	assign ch0_out     = s.ch_out;
	assign ovf_irq_out = s.ovf_irq;
	assign ch0_irq_out = s.ch0_irq;

endmodule

// ===== test/ebt_timer_checker.sv
`timescale 1ns/1ns
module ebt_timer_checker
	import ebt_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        rst_in,
	input wire logic        tick_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [9:0]  wb_adr_in,
	input wire logic [3:0]  wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	input wire logic        ch0_out,
	input wire logic        ovf_irq_out,
	input wire logic        ch0_irq_out
);
	logic req;
	logic wr;
	assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr = req && wb_we_in;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////
	sequence s_take; req; endsequence
	sequence s_answer; wb_ack_out ##1 !wb_ack_out; endsequence
	a_ack_next: assert property (s_take |=> s_answer) else $error("ack late");
	a_ack_cause: assert property (!req |=> !wb_ack_out) else $error("ack without request");
	a_dat_upper: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_dat_hold: assert property (!req |=> $stable(wb_dat_out)) else $error("read data moved");
	a_reset_out: assert property (disable iff (1'b0) rst_in |=> !wb_ack_out && !ch0_out
		&& !ovf_irq_out && !ch0_irq_out) else $error("outputs not cleared");
	// Irq outputs move at the very edge that takes the step or the write
	a_ovf_rise: assert property ($rose(ovf_irq_out) |-> $past(tick_in) || $past(wr))
		else $error("overflow irq without cause");
	a_ovf_fall: assert property ($fell(ovf_irq_out) |-> $past(wr))
		else $error("overflow irq dropped alone");
	a_ch0_rise: assert property ($rose(ch0_irq_out) |-> $past(tick_in) || $past(wr))
		else $error("channel irq without cause");
	a_ch0_fall: assert property ($fell(ch0_irq_out) |-> $past(wr))
		else $error("channel irq dropped alone");
	a_out_step: assert property ($changed(ch0_out) |-> $past(tick_in))
		else $error("output moved without step");
endmodule

bind ebt_timer ebt_timer_checker chk_u (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
	.wb_ack_out(wb_ack_out), .ch0_out(ch0_out), .ovf_irq_out(ovf_irq_out),
	.ch0_irq_out(ch0_irq_out));

// ===== test/eight_bit_timer_with_compare_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin \
	$display("wrong value %s exp %h got %h", n, e, a); n_mismatch++; end end
module eight_bit_timer_with_compare_tb;
	import ebt_pkg::*;
	logic        mclk_in = 1'b0, rst_in = 1'b1, tick_in = 1'b0, cyc = 1'b0, we = 1'b0;
	logic [9:0]  adr = '0;
	logic [3:0]  sel = 4'h1;
	logic [31:0] wdat = '0;
	logic [31:0] rdat;
	logic        ack, ch0, ovf_irq, ch0_irq;
	logic [7:0]  e;
	logic [7:0]  expq[$];
	logic [1:0]  ae[8] = '{2'b11, 2'b00, 2'b11, 2'b10, 2'b01, 2'b11, 2'b01, 2'b11};
	logic [2:0]  d, n;
	int          n_mismatch = 0, checked = 0, cycles = 0, seed = 32'h6e99;
	ebt_timer dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick_in), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .ch0_out(ch0), .ovf_irq_out(ovf_irq),
		.ch0_irq_out(ch0_irq));
	always #5 mclk_in = ~mclk_in;
	////////////////////////////////////////
	task automatic end_of_test;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Leading edge keeps one idle cycle between requests
	task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] dv);
		@(posedge mclk_in);
		cyc <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h00_0000, dv};
		do @(posedge mclk_in); while (ack !== 1'b1);
		cyc <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] dv);
		bus(idx, 1'b1, dv);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] ev);
		expq.push_back(ev);
		bus(idx, 1'b0, 8'h00);
	endtask
	task automatic tk(input int k);
		repeat (k) begin
			@(posedge mclk_in);
			tick_in <= 1'b1;
		end
		@(posedge mclk_in);
		tick_in <= 1'b0;
	endtask
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles > 20000) begin
			n_mismatch++;
			end_of_test();
		end
		if (ack && !we) begin
			e = expq.pop_front();
			`CHK("read data", {24'h00_0000, e}, rdat)
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		rd(8'hea, 8'h00);
		rd(8'heb, 8'h08);
		rd(8'hec, 8'h40);
		rd(8'hed, 8'h00);
		rd(8'hd8, 8'h00);
		tk(3);
		rd(8'hea, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(8'heb, {i[2:0], 5'h10});
			tk(1 << i);
		end
		rd(8'hea, 8'h08);
		d = 3'($random(seed) & 3);
		n = 3'($random(seed) & 7);
		wr(8'heb, {d, 5'h10});
		tk(int'(n) << d);
		rd(8'hea, 8'h08 + 8'(n));
		wr(8'hea, 8'h77);
		wr(8'heb, 8'h1c);
		rd(8'heb, 8'h18);
		tk(255);
		rd(8'hea, 8'hff);
		rd(8'hd8, 8'h00);
		tk(1);
		rd(8'hea, 8'h00);
		rd(8'hd8, 8'h08);
		`CHK("ovf irq", 1'b1, ovf_irq)
		wr(8'hd8, 8'h18);
		rd(8'hd8, 8'h08);
		wr(8'heb, 8'h10);
		#1 `CHK("ovf irq masked", 1'b0, ovf_irq)
		wr(8'hd8, 8'h00);
		wr(8'hed, 8'h03);
		rd(8'hed, 8'h03);
		wr(8'heb, 8'h1e);
		for (int a = 0; a < 8; a++) begin
			wr(8'hec, {2'b01, a[2:0], 3'b100});
			tk(3);
			#1 `CHK("out at match", ae[a][1], ch0)
			tk(1);
			#1 `CHK("out at zero", ae[a][0], ch0)
		end
		rd(8'hd8, 8'h18);
		`CHK("ch0 irq", 1'b1, ch0_irq)
		wr(8'hec, 8'h08);
		#1 `CHK("ch0 irq masked", 1'b0, ch0_irq)
		tk(4);
		#1 `CHK("out disabled", 1'b1, ch0)
		wr(8'hed, 8'h02);
		wr(8'heb, 8'h1f);
		tk(3);
		rd(8'hea, 8'h01);
		tk(1);
		rd(8'hea, 8'h00);
		wr(8'hed, 8'h05);
		wr(8'heb, 8'h19);
		rd(8'hea, 8'h05);
		tk(2);
		rd(8'hea, 8'h03);
		tk(5);
		rd(8'hea, 8'h00);
		sel <= 4'h0;
		wr(8'hed, 8'haa);
		sel <= 4'h1;
		rd(8'hed, 8'h05);
		wr(8'h40, 8'hff);
		rd(8'h40, 8'h00);
		@(posedge mclk_in);
		end_of_test();
	end
endmodule
